// File: lptc_defines.svh
/*
 Offsets, field positions, reset values and timing counts of the protection test control block.
 Assumes inclusion by the test control design file of this block only.
*/
`ifndef LPTC_DEFINES_SVH
`define LPTC_DEFINES_SVH
`define LPTC_ADDR_TEST_CTRL 8'hC0
`define LPTC_ADDR_INDIRECT_STS 8'hC4
`define LPTC_ADDR_FRAME_STS 8'hC8
`define LPTC_ADDR_CHECK_STS 8'hCC
`define LPTC_TEST_CTRL_RESET 8'h00
`define LPTC_TEST_CTRL_WMASK 8'h5F
`define LPTC_BIT_TO_DIS 6
`define LPTC_BIT_SYNC_DIS 4
`define LPTC_BIT_CKSUM_EN 3
`define LPTC_BIT_FC_ACCEL 2
`define LPTC_BIT_TMR_ACCEL 1
`define LPTC_BIT_FAST 0
`define LPTC_BUS_TIMEOUT_MS 1000
`define LPTC_CLK_KHZ 200000
`define LPTC_BUS_TIMEOUT_CYC (`LPTC_BUS_TIMEOUT_MS * `LPTC_CLK_KHZ + 1)
`define LPTC_PJ_PERIOD_NORM 16
`define LPTC_PJ_PERIOD_FAST 2
`define LPTC_RI_PERIOD_NORM 128
`define LPTC_RI_PERIOD_FAST 16
`define LPTC_TMR_ACCEL_SHIFT 4
`endif

// File: lptc_pkg.sv
/*
 Types shared by the protection test control block.
 Assumes the defines header sits in the same folder.
*/
package lptc_pkg;
	typedef logic [7:0] lptc_byte_t;
	typedef enum logic [1:0] {
		LPTC_SUM_IDLE,
		LPTC_SUM_LINE,
		LPTC_SUM_EMIT
	} lptc_sum_e;
endpackage

// File: lptc_checksum.sv
/*
 Per-line ones-complement checksum of three 8-bit colour channels.
 Assumes pixels arrive on the core clock with a valid strobe and a one-cycle end-of-line pulse.
*/
`timescale 1ns/1ps
module lptc_checksum (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic pix_valid,
	input wire logic line_end,
	input wire logic [23:0] pix_rgb,
	output logic sum_valid_ff,
	output logic [23:0] sum_rgb_ff
);
	import lptc_pkg::*;

	logic [23:0] acc_ff;
	lptc_sum_e state_ff;

	// End-around carry keeps the sum in ones-complement form.
	function automatic lptc_byte_t oc_add(input lptc_byte_t a, input lptc_byte_t b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		oc_add = s[7:0] + {7'h00, s[8]};
	endfunction

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			acc_ff <= 24'h000000;
			state_ff <= LPTC_SUM_IDLE;
		end else if (line_end) begin
			acc_ff <= 24'h000000;
			state_ff <= enable ? LPTC_SUM_EMIT : LPTC_SUM_IDLE;
		end else if (pix_valid) begin
			acc_ff <= {oc_add(acc_ff[23:16], pix_rgb[23:16]), oc_add(acc_ff[15:8], pix_rgb[15:8]),
				oc_add(acc_ff[7:0], pix_rgb[7:0])};
			state_ff <= LPTC_SUM_LINE;
		end else if (state_ff == LPTC_SUM_EMIT) begin
			state_ff <= LPTC_SUM_IDLE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			sum_valid_ff <= 1'b0;
			sum_rgb_ff <= 24'h000000;
		end else begin
			sum_valid_ff <= line_end && enable;
			if (line_end && enable) begin
				sum_rgb_ff <= ~{oc_add(acc_ff[23:16], pix_valid ? pix_rgb[23:16] : 8'h00),
					oc_add(acc_ff[15:8], pix_valid ? pix_rgb[15:8] : 8'h00),
					oc_add(acc_ff[7:0], pix_valid ? pix_rgb[7:0] : 8'h00)};
			end
		end
	end
endmodule // lptc_checksum

// File: lptc_test_control.sv
/*
 Test and debug control register of the link protection transmitter with the logic it steers.
 Assumes a single-cycle register port on mclk, frame and line strobes from the video path, and
 key bus activity from the key-exchange bus pins.
*/
// The implementer's own choice: strobed register access.
//
// Function
// - While the timeout disable bit is clear, the key bus is taken as free after more than 1 s with no signalling.
// - The integrity value is normally compared both before and after the start of frame 128.
// - With the sync check disable bit set, the integrity comparison at frame 127 is skipped.
// - With the line checksum bit set, a ones-complement checksum per 8-bit colour follows each line.
// - With frame counter acceleration set, the pixel check runs every 2 frames and the integrity check every 16.
// - With frame counter acceleration clear, the pixel check runs every 16 frames while enhanced link verification is enabled, and the integrity check every 128.
// - With timer acceleration set, the authentication timers run faster than normal.
// - The key bus uses fast timing when the fast select bit is 1, standard timing otherwise.
// - The fast select bit is mirrored into the indirect status register.
// - With enhanced link verification enabled and frame counter acceleration clear, the pixel check value is checked on every 16th frame.
`timescale 1ns/1ps
`include "lptc_defines.svh"
module lptc_test_control #(
	parameter int unsigned BUS_TIMEOUT_CYC = `LPTC_BUS_TIMEOUT_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output lptc_pkg::lptc_byte_t reg_rdata_ff,
	input wire logic enhanced_link_verify_enable,
	input wire logic frame_start,
	input wire logic pix_valid,
	input wire logic line_end,
	input wire logic [23:0] pix_rgb,
	input wire logic key_scl_pin,
	input wire logic key_sda_pin,
	input wire logic auth_tick,
	output logic key_bus_free_ff,
	output logic key_bus_fast_ff,
	output logic pixel_check_strobe_ff,
	output logic integrity_check_strobe_ff,
	output logic auth_timer_tick_ff,
	output logic line_sum_valid_ff,
	output logic [23:0] line_sum_rgb_ff
);
	import lptc_pkg::*;

	lptc_byte_t ctrl_ff;
	logic [1:0] scl_sync_ff;
	logic [1:0] sda_sync_ff;
	logic scl_last_ff;
	logic sda_last_ff;
	logic [31:0] idle_cnt_ff;
	logic [6:0] frame_cnt_ff;
	logic [3:0] tmr_div_ff;
	logic sum_valid;
	logic [23:0] sum_rgb;

	wire to_dis = ctrl_ff[`LPTC_BIT_TO_DIS];
	wire sync_dis = ctrl_ff[`LPTC_BIT_SYNC_DIS];
	wire fc_accel = ctrl_ff[`LPTC_BIT_FC_ACCEL];
	wire tmr_accel = ctrl_ff[`LPTC_BIT_TMR_ACCEL];
	wire key_activity = (scl_sync_ff[1] != scl_last_ff) || (sda_sync_ff[1] != sda_last_ff);

	// True when the count reached after this frame start closes a period; periods are powers of two.
	// The sum is taken one bit wider so that a 128-frame period still has a non-zero mask.
	function automatic logic is_period_end(input logic [6:0] cnt, input logic [7:0] period);
		logic [7:0] reached;
		reached = {1'b0, cnt} + 8'h01;
		is_period_end = (reached & (period - 8'h01)) == 8'h00;
	endfunction

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_ff <= `LPTC_TEST_CTRL_RESET;
		end else if (reg_wr && reg_addr == `LPTC_ADDR_TEST_CTRL) begin
			ctrl_ff <= reg_wdata & `LPTC_TEST_CTRL_WMASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			reg_rdata_ff <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`LPTC_ADDR_TEST_CTRL: reg_rdata_ff <= ctrl_ff & `LPTC_TEST_CTRL_WMASK;
				`LPTC_ADDR_INDIRECT_STS: reg_rdata_ff <= {7'h00, ctrl_ff[`LPTC_BIT_FAST]};
				`LPTC_ADDR_FRAME_STS: reg_rdata_ff <= {1'b0, frame_cnt_ff};
				`LPTC_ADDR_CHECK_STS: reg_rdata_ff <= {7'h00, key_bus_free_ff};
				default: reg_rdata_ff <= 8'h00;
			endcase
		end else begin
			reg_rdata_ff <= 8'h00;
		end
	end

	// Pins are asynchronous to mclk, so only the second stage is compared.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scl_sync_ff <= 2'b11;
			sda_sync_ff <= 2'b11;
			scl_last_ff <= 1'b1;
			sda_last_ff <= 1'b1;
		end else begin
			scl_sync_ff <= {scl_sync_ff[0], key_scl_pin};
			sda_sync_ff <= {sda_sync_ff[0], key_sda_pin};
			scl_last_ff <= scl_sync_ff[1];
			sda_last_ff <= sda_sync_ff[1];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			idle_cnt_ff <= 32'h00000000;
			key_bus_free_ff <= 1'b0;
		end else if (key_activity || to_dis) begin
			idle_cnt_ff <= 32'h00000000;
			key_bus_free_ff <= 1'b0;
		end else if (idle_cnt_ff >= BUS_TIMEOUT_CYC - 1) begin
			key_bus_free_ff <= 1'b1;
		end else begin
			idle_cnt_ff <= idle_cnt_ff + 32'h00000001;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			key_bus_fast_ff <= 1'b0;
		end else begin
			key_bus_fast_ff <= ctrl_ff[`LPTC_BIT_FAST];
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			frame_cnt_ff <= 7'h00;
			pixel_check_strobe_ff <= 1'b0;
			integrity_check_strobe_ff <= 1'b0;
		end else begin
			pixel_check_strobe_ff <= 1'b0;
			integrity_check_strobe_ff <= 1'b0;
			if (frame_start) begin
				frame_cnt_ff <= frame_cnt_ff + 7'h01;
				if (fc_accel) begin
					pixel_check_strobe_ff <= is_period_end(frame_cnt_ff, 8'(`LPTC_PJ_PERIOD_FAST));
					integrity_check_strobe_ff <= is_period_end(frame_cnt_ff, 8'(`LPTC_RI_PERIOD_FAST)) ||
						(!sync_dis && is_period_end(frame_cnt_ff + 7'h01, 8'(`LPTC_RI_PERIOD_FAST)));
				end else begin
					pixel_check_strobe_ff <= enhanced_link_verify_enable &&
						is_period_end(frame_cnt_ff, 8'(`LPTC_PJ_PERIOD_NORM));
					// Frame 127 check confirms sync ahead of the frame 128 compare.
					integrity_check_strobe_ff <= is_period_end(frame_cnt_ff, 8'(`LPTC_RI_PERIOD_NORM)) ||
						(!sync_dis && is_period_end(frame_cnt_ff + 7'h01, 8'(`LPTC_RI_PERIOD_NORM)));
				end
			end
		end
	end

	// A 4-bit divider passes one tick per 16 auth_tick pulses; the speedup drives the tick on every mclk cycle.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tmr_div_ff <= 4'h0;
			auth_timer_tick_ff <= 1'b0;
		end else if (tmr_accel) begin
			auth_timer_tick_ff <= 1'b1;
		end else begin
			tmr_div_ff <= tmr_div_ff + {3'h0, auth_tick};
			auth_timer_tick_ff <= auth_tick && tmr_div_ff == 4'hF;
		end
	end

	lptc_checksum u_checksum (
		.mclk(mclk),
		.rst_n(rst_n),
		.enable(ctrl_ff[`LPTC_BIT_CKSUM_EN]),
		.pix_valid(pix_valid),
		.line_end(line_end),
		.pix_rgb(pix_rgb),
		.sum_valid_ff(sum_valid),
		.sum_rgb_ff(sum_rgb)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			line_sum_valid_ff <= 1'b0;
			line_sum_rgb_ff <= 24'h000000;
		end else begin
			line_sum_valid_ff <= sum_valid;
			line_sum_rgb_ff <= sum_rgb;
		end
	end

	sequence s_wr_ctrl;
		reg_wr && reg_addr == `LPTC_ADDR_TEST_CTRL;
	endsequence
	property p_reserved_zero;
		@(posedge mclk) disable iff (!rst_n) ctrl_ff[7] == 1'b0 && ctrl_ff[5] == 1'b0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bit set.");
	property p_mirror;
		@(posedge mclk) disable iff (!rst_n)
			s_wr_ctrl ##1 (!reg_wr) ##0 (reg_rd && reg_addr == `LPTC_ADDR_INDIRECT_STS) |=>
			reg_rdata_ff[0] == $past(reg_wdata[0], 2);
	endproperty
	a_mirror: assert property (p_mirror) else $error("Indirect status lost fast bit.");
	property p_fast;
		@(posedge mclk) disable iff (!rst_n) s_wr_ctrl |-> ##2 key_bus_fast_ff == $past(reg_wdata[0], 2);
	endproperty
	a_fast: assert property (p_fast) else $error("Fast select not applied.");
	property p_timeout_dis;
		@(posedge mclk) disable iff (!rst_n) to_dis |=> !key_bus_free_ff;
	endproperty
	a_timeout_dis: assert property (p_timeout_dis) else $error("Timeout active while disabled.");
	property p_free_after_idle;
		@(posedge mclk) disable iff (!rst_n) $rose(key_bus_free_ff) |-> idle_cnt_ff >= BUS_TIMEOUT_CYC - 1;
	endproperty
	a_free_after_idle: assert property (p_free_after_idle) else $error("Bus freed early.");
	property p_pj_accel;
		@(posedge mclk) disable iff (!rst_n) pixel_check_strobe_ff && fc_accel |-> frame_cnt_ff[0] == 1'b0;
	endproperty
	a_pj_accel: assert property (p_pj_accel) else $error("Pixel check off its 2-frame period.");
	property p_pj_norm;
		@(posedge mclk) disable iff (!rst_n) pixel_check_strobe_ff && !fc_accel |-> frame_cnt_ff[3:0] == 4'h0;
	endproperty
	a_pj_norm: assert property (p_pj_norm) else $error("Pixel check off its 16-frame period.");
	property p_sync_skip;
		@(posedge mclk) disable iff (!rst_n)
			integrity_check_strobe_ff && sync_dis && !fc_accel |-> frame_cnt_ff == 7'h00;
	endproperty
	a_sync_skip: assert property (p_sync_skip) else $error("Frame 127 check not skipped.");
	property p_ri_pair;
		@(posedge mclk) disable iff (!rst_n)
			integrity_check_strobe_ff && !sync_dis && !fc_accel |-> frame_cnt_ff == 7'h7F || frame_cnt_ff == 7'h00;
	endproperty
	a_ri_pair: assert property (p_ri_pair) else $error("Integrity check off frames 127 and 128.");
	property p_tmr_accel;
		@(posedge mclk) disable iff (!rst_n) tmr_accel |=> auth_timer_tick_ff;
	endproperty
	a_tmr_accel: assert property (p_tmr_accel) else $error("Timer tick not accelerated.");
	property p_sum;
		@(posedge mclk) disable iff (!rst_n) line_end && ctrl_ff[`LPTC_BIT_CKSUM_EN] |-> ##2 line_sum_valid_ff;
	endproperty
	a_sum: assert property (p_sum) else $error("Line checksum missing.");
endmodule // lptc_test_control

// File: lptc_partner.sv
/*
 Video source and key bus pins facing the protection test control block.
 Assumes the bench calls its tasks from one process, clocked by mclk.
*/
`timescale 1ns/1ps
module lptc_partner (
	input wire logic mclk,
	output logic frame_start,
	output logic pix_valid,
	output logic line_end,
	output logic [23:0] pix_rgb,
	output logic key_scl_pin,
	output logic key_sda_pin
);
	// The key pins idle high as a pulled-up bus would.
	initial begin
		frame_start = 1'b0;
		pix_valid = 1'b0;
		line_end = 1'b0;
		pix_rgb = 24'hA5A5A5;
		key_scl_pin = 1'b1;
		key_sda_pin = 1'b1;
	end
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge mclk) frame_start <= 1'b1;
			@(posedge mclk) frame_start <= 1'b0;
			repeat (2) @(posedge mclk);
		end
	endtask
	// Outside a line the pixel word is inverted, so a stale value is never taken for data.
	task automatic send_line(input logic [23:0] p0, input logic [23:0] p1);
		@(posedge mclk) pix_valid <= 1'b1;
		pix_rgb <= p0;
		@(posedge mclk) pix_rgb <= p1;
		line_end <= 1'b1;
		@(posedge mclk) pix_valid <= 1'b0;
		line_end <= 1'b0;
		pix_rgb <= ~p1;
	endtask
	task automatic poke();
		@(posedge mclk) key_scl_pin <= 1'b0;
		@(posedge mclk) key_scl_pin <= 1'b1;
	endtask
endmodule // lptc_partner

// File: tb_top.sv
/*
 Self-checking bench of the protection test control block.
 Assumes the design files and the partner model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
	logic mclk, rst_n, reg_wr, reg_rd, enh, auth_tick, fs, pv, le, scl, sda;
	logic [7:0] reg_addr, reg_wdata;
	logic [23:0] rgb, sum_rgb;
	lptc_pkg::lptc_byte_t rdata;
	logic bus_free, fast, pix_s, int_s, tick_o, sum_v;
	int n_fail, n_checks, n_pix, n_int, n_tick, n_sum;
	logic [23:0] last_sum;
	// A short timeout keeps the idle bus test within a few dozen cycles.
	lptc_test_control #(.BUS_TIMEOUT_CYC(50)) i_lptc_test_control (.mclk(mclk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
		.enhanced_link_verify_enable(enh), .frame_start(fs), .pix_valid(pv), .line_end(le), .pix_rgb(rgb),
		.key_scl_pin(scl), .key_sda_pin(sda), .auth_tick(auth_tick), .key_bus_free_ff(bus_free),
		.key_bus_fast_ff(fast), .pixel_check_strobe_ff(pix_s), .integrity_check_strobe_ff(int_s),
		.auth_timer_tick_ff(tick_o), .line_sum_valid_ff(sum_v), .line_sum_rgb_ff(sum_rgb));
	lptc_partner i_lptc_partner (.mclk(mclk), .frame_start(fs), .pix_valid(pv), .line_end(le),
		.pix_rgb(rgb), .key_scl_pin(scl), .key_sda_pin(sda));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (pix_s === 1'b1) n_pix++;
		if (int_s === 1'b1) n_int++;
		if (tick_o === 1'b1) n_tick++;
		if (sum_v === 1'b1) begin
			n_sum++;
			last_sum = sum_rgb;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk) reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk) reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk) reg_rd <= 1'b0;
		#1 chk({24'h000000, rdata}, {24'h000000, exp});
	endtask
	// Write then read with no idle cycle between the strobes, as the bus allows.
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] ra, input logic [7:0] exp);
		@(posedge mclk) reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk) reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= ra;
		@(posedge mclk) reg_rd <= 1'b0;
		#1 chk({24'h000000, rdata}, {24'h000000, exp});
	endtask
	task automatic clr();
		#1 n_pix = 0;
		n_int = 0;
		n_tick = 0;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#200000 n_fail++;
		finish_test();
	end
	initial begin
		{rst_n, reg_wr, reg_rd, enh, auth_tick, n_fail, n_checks, n_sum} = '0;
		{reg_addr, reg_wdata} = 16'h0000;
		clr();
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rd(8'hC0, 8'h00);
		rd(8'h10, 8'h00);
		wr_rd(8'hC0, 8'hFF, 8'hC4, 8'h01);
		rd(8'hC0, 8'h5F);
		chk({31'h0, fast}, 32'h1);
		wr(8'hC0, 8'h00);
		rd(8'hC4, 8'h00);
		chk({31'h0, fast}, 32'h0);
		wr(8'hC0, 8'h14);
		clr();
		i_lptc_partner.frames(16);
		chk(n_pix, 8);
		chk(n_int, 1);
		wr(8'hC0, 8'h04);
		clr();
		i_lptc_partner.frames(16);
		chk(n_pix, 8);
		chk(n_int, 2);
		wr(8'hC0, 8'h00);
		enh <= 1'b1;
		clr();
		i_lptc_partner.frames(128);
		chk(n_pix, 8);
		chk(n_int, 2);
		enh <= 1'b0;
		clr();
		i_lptc_partner.frames(16);
		chk(n_pix, 0);
		wr(8'hC0, 8'h10);
		clr();
		i_lptc_partner.frames(128);
		chk(n_int, 1);
		rd(8'hC8, 8'h30);
		wr(8'hC0, 8'h08);
		i_lptc_partner.send_line(24'h10F0FF, 24'h202002);
		repeat (4) @(posedge mclk);
		chk(n_sum, 1);
		chk({8'h00, last_sum}, 32'h00CFEEFD);
		wr(8'hC0, 8'h00);
		i_lptc_partner.send_line(24'h010203, 24'h040506);
		repeat (4) @(posedge mclk);
		chk(n_sum, 1);
		wr(8'hC0, 8'h02);
		repeat (3) @(posedge mclk);
		#1 chk({31'h0, tick_o}, 32'h1);
		wr(8'hC0, 8'h00);
		repeat (2) @(posedge mclk);
		clr();
		repeat (32) begin
			@(posedge mclk) auth_tick <= 1'b1;
			@(posedge mclk) auth_tick <= 1'b0;
		end
		repeat (3) @(posedge mclk);
		chk(n_tick, 2);
		i_lptc_partner.poke();
		repeat (20) @(posedge mclk);
		#1 chk({31'h0, bus_free}, 32'h0);
		repeat (40) @(posedge mclk);
		#1 chk({31'h0, bus_free}, 32'h1);
		rd(8'hCC, 8'h01);
		i_lptc_partner.poke();
		repeat (6) @(posedge mclk);
		#1 chk({31'h0, bus_free}, 32'h0);
		wr(8'hC0, 8'h40);
		rd(8'hC0, 8'h40);
		repeat (60) @(posedge mclk);
		#1 chk({31'h0, bus_free}, 32'h0);
		finish_test();
	end
endmodule // tb_top
